// File: core/pacr_regs.sv
// pa controller configuration register bank with pin, clamp and ramp control
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module pacr_regs
  import pacr_pkg::*;
#(
  parameter int RAMP_STEP_CYC = RAMP_STEP_CYC_DEF
) (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  // register access from the serial front end
  input  wire pacr_req_t   i_req,
  output logic [15:0]      o_rdata,
  // multifunction pins
  input  wire logic [7:0]  i_pin_in,
  input  wire logic [7:0]  i_gpio_out,
  output logic [7:0]       o_pin_out,
  output logic [7:0]       o_pin_oe_n,
  // dedicated function levels from the core (active high)
  input  wire logic        i_conv_busy,
  input  wire logic [4:0]  i_raw_alert,
  input  wire logic [3:0]  i_integrator_limit_status,
  input  wire logic        i_supply_alarm,
  input  wire logic        i_acq_start,
  input  wire logic [3:0]  i_ramp_target_step,
  // control outputs
  output logic             o_acq_done,
  output logic [7:0]       o_dac_clamp,
  output logic [7:0]       o_dac_powered,
  output logic             o_amp_on_pin,
  output logic [3:0]       o_ramp_step,
  output logic [3:0]       o_fast_ramp_en,
  output logic [11:0]      o_integrator_tc,
  output logic             o_int_ref_sel,
  output logic             o_diode_check_on,
  output logic             o_limit_amp_ctrl,
  output logic [15:0]      o_curr_gain,
  output logic [15:0]      o_temp_bg_en,
  output logic [15:0]      o_curr_bg_en,
  output logic [15:0]      o_mon_bg_en,
  output logic [4:0]       o_alert_status,
  output logic             o_loop_limit_cfg_valid
);

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] out_en_r, func_r, pol_r, gen_r, acq_r, temp_bg_r, curr_bg_r;
  logic [15:0] gain_r, clp0_r, clp1_r, mon_bg_r, loop_r, amp_r, fast_r, mask_r;
  logic [15:0] ramp_r [4];
  logic [7:0]  dac_en_r;
  logic [7:0]  pin_s1_r, pin_s2_r;
  logic        wr_hit, first_alert_out_lvl, second_alert_out_lvl;

  // pin inputs come from outside, two flops before use
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
    end else begin
      pin_s1_r <= i_pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // dedicated inputs seen through polarity, only in function mode
  logic [7:0] pin_act;
  assign pin_act = (pin_s2_r ^ pol_r[7:0]) & ~func_r[7:0];
  logic first_sleep_pin, second_sleep_pin, sleep_any;
  assign first_sleep_pin    = pin_act[PIN_FIRST_SLEEP_PIN];
  assign second_sleep_pin    = pin_act[PIN_SECOND_SLEEP_PIN];
  assign sleep_any = first_sleep_pin | second_sleep_pin;

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  assign wr_hit = i_req.wr;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_en_r  <= RST_PIN_OUT_EN;
      func_r    <= RST_PIN_FUNC;
      pol_r     <= RST_PIN_POL;
      gen_r     <= RST_ZERO;
      acq_r     <= RST_ZERO;
      temp_bg_r <= RST_ZERO;
      curr_bg_r <= RST_ZERO;
      gain_r    <= RST_ZERO;
      clp0_r    <= RST_CLAMP_SLP;
      clp1_r    <= RST_CLAMP_SLP;
      mon_bg_r  <= RST_ZERO;
      loop_r    <= RST_ZERO;
      fast_r    <= RST_FAST_RAMP;
      mask_r    <= RST_ZERO;
      for (int i = 0; i < 4; i++) ramp_r[i] <= RST_ZERO;
    end else if (wr_hit) begin
      case (i_req.addr)
        OFS_PIN_OUT_EN: out_en_r  <= i_req.wdata & MSK_BYTE;
        OFS_PIN_FUNC:   func_r    <= i_req.wdata & MSK_BYTE;
        OFS_PIN_POL:    pol_r     <= i_req.wdata & MSK_BYTE;
        OFS_GENERAL:    gen_r     <= i_req.wdata & MSK_GENERAL;
        OFS_ACQ_DELAY:  acq_r     <= i_req.wdata;
        OFS_TEMP_BG:    temp_bg_r <= i_req.wdata;
        OFS_CURR_BG:    curr_bg_r <= i_req.wdata;
        OFS_CURR_GAIN:  gain_r    <= i_req.wdata;
        OFS_CLAMP_SLP0: clp0_r    <= i_req.wdata;
        OFS_CLAMP_SLP1: clp1_r    <= i_req.wdata;
        OFS_MON_BG:     mon_bg_r  <= i_req.wdata;
        OFS_LOOP_LIMIT: loop_r    <= i_req.wdata;
        OFS_FAST_RAMP:  fast_r    <= i_req.wdata;
        OFS_ALARM_MASK: mask_r    <= i_req.wdata;
        OFS_RAMP_CH0:   ramp_r[0] <= i_req.wdata;
        OFS_RAMP_CH1:   ramp_r[1] <= i_req.wdata;
        OFS_RAMP_CH2:   ramp_r[2] <= i_req.wdata;
        OFS_RAMP_CH3:   ramp_r[3] <= i_req.wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dac clamp and snooze
  logic [7:0] clamp_now;
  assign clamp_now = ({8{first_sleep_pin}} & clp0_r[7:0])
                   | ({8{second_sleep_pin}} & clp1_r[7:0])
                   | ({8{first_alert_out_lvl & gen_r[GEN_A0_CLAMP]}} & 8'h0f);

  logic [7:0] snooze;
  assign snooze = ({8{first_sleep_pin}} & clp0_r[15:CLP_SNOOZE_LSB])
                | ({8{second_sleep_pin}} & clp1_r[15:CLP_SNOOZE_LSB]);

  // snoozed dac loses power on clamp and waits for a dac enable write
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dac_en_r <= 8'hff;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (clamp_now[i] && snooze[i]) begin
          dac_en_r[i] <= 1'b0;
        end else if (wr_hit && i_req.addr == OFS_DAC_ENABLE) begin
          dac_en_r[i] <= i_req.wdata[i];
        end
      end
    end
  end
  assign o_dac_clamp   = clamp_now;
  assign o_dac_powered = dac_en_r & ~clamp_now;

  ////////////////////////////////////////////////////////////////////////////
  // amp-on pin: control bit holds on-state, alarm and sleep force it off, sleep with snooze latches it off
  logic amp_latch_off_r;
  logic amp_alarm_hold;
  assign amp_alarm_hold = amp_r[AMP_ALARM_EN] & i_supply_alarm;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      amp_r           <= RST_AMP_ON_CTRL;
      amp_latch_off_r <= 1'b0;
    end else begin
      if (wr_hit && i_req.addr == OFS_AMP_ON_CTRL) begin
        amp_r <= i_req.wdata;
      end
      // set wins: a sleep during the write still latches off
      if (amp_r[AMP_CLAMP_EN] && sleep_any && amp_r[AMP_SNOOZE]) begin
        amp_latch_off_r <= 1'b1;
      end else if (wr_hit && i_req.addr == OFS_AMP_ON_CTRL) begin
        amp_latch_off_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_amp_on_pin <= 1'b0;
    end else begin
      o_amp_on_pin <= amp_r[AMP_ON_BIT] & ~amp_alarm_hold
                    & ~(amp_r[AMP_CLAMP_EN] & sleep_any)
                    & ~amp_latch_off_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // acquisition delay counter for voltage-input command conversions
  logic [31:0] acq_cnt_r;
  logic        acq_busy_r;
  logic [31:0] acq_total;
  assign acq_total = 32'(acq_r) * 32'(ACQ_STEP_CYC);

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      acq_cnt_r  <= 32'h0;
      acq_busy_r <= 1'b0;
      o_acq_done <= 1'b0;
    end else begin
      o_acq_done <= 1'b0;
      if (i_acq_start && !acq_busy_r) begin
        if (acq_total == 32'h0) begin
          o_acq_done <= 1'b1;
        end else begin
          acq_cnt_r  <= acq_total - 32'h1;
          acq_busy_r <= 1'b1;
        end
      end else if (acq_busy_r) begin
        if (acq_cnt_r == 32'h0) begin
          acq_busy_r <= 1'b0;
          o_acq_done <= 1'b1;
        end else begin
          acq_cnt_r <= acq_cnt_r - 32'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // setpoint ramp: one step pulse per channel each programmed interval
  logic [31:0] ramp_tick_r;
  logic        ramp_tick;
  assign ramp_tick = (ramp_tick_r == 32'(RAMP_STEP_CYC - 1));

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ramp_tick_r <= 32'h0;
    end else begin
      ramp_tick_r <= ramp_tick ? 32'h0 : ramp_tick_r + 32'h1;
    end
  end

  logic [15:0] ramp_eff [4];
  logic [15:0] ramp_cnt_r [4];
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (ramp_r[i] == RST_ZERO) begin
        ramp_eff[i] = RST_ZERO;
      end else if (ramp_r[i] < RAMP_MIN_CNT) begin
        ramp_eff[i] = RAMP_MIN_CNT;
      end else if (ramp_r[i] > RAMP_MAX_CNT) begin
        ramp_eff[i] = RAMP_MAX_CNT;
      end else begin
        ramp_eff[i] = ramp_r[i];
      end
    end
  end

  // step spacing = clamped ramp register value (ramp length), in 250 us ticks
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < 4; i++) ramp_cnt_r[i] <= RST_ZERO;
      o_ramp_step <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        o_ramp_step[i] <= 1'b0;
        if (ramp_eff[i] == RST_ZERO) begin
          o_ramp_step[i]   <= i_ramp_target_step[i];
          ramp_cnt_r[i]    <= RST_ZERO;
        end else if (i_ramp_target_step[i] && ramp_tick) begin
          if (ramp_cnt_r[i] >= ramp_eff[i] - 16'h1) begin
            ramp_cnt_r[i]  <= RST_ZERO;
            o_ramp_step[i] <= 1'b1;
          end else begin
            ramp_cnt_r[i]  <= ramp_cnt_r[i] + 16'h1;
          end
        end
      end
    end
  end

  assign o_fast_ramp_en  = {fast_r[15], fast_r[11], fast_r[7], fast_r[3]};
  assign o_integrator_tc = {fast_r[14:12], fast_r[10:8], fast_r[6:4], fast_r[2:0]};

  ////////////////////////////////////////////////////////////////////////////
  // alert status, masking and pin routing
  logic [4:0] alert_vis;
  assign alert_vis = {i_supply_alarm & ~mask_r[MSK_SUPPLY_BIT],
                      i_integrator_limit_status & ~mask_r[3:0]};
  assign o_alert_status = alert_vis;

  logic [3:0] gpio_in_stat;
  assign gpio_in_stat = pin_s2_r[3:0] & func_r[3:0] & ~out_en_r[3:0];

  assign first_alert_out_lvl = |(alert_vis & i_raw_alert);
  assign second_alert_out_lvl = first_alert_out_lvl
                    | (gen_r[GEN_GPIO_ALERT] & (|gpio_in_stat));

  logic [7:0] func_out;
  assign func_out = {1'b0, 2'b00, second_alert_out_lvl, first_alert_out_lvl, i_conv_busy, 2'b00};

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pin_out  <= 8'h00;
      o_pin_oe_n <= 8'hff;
    end else begin
      for (int i = 0; i < 8; i++) begin
        o_pin_out[i] <= func_r[i] ? i_gpio_out[i] : (func_out[i] ^ pol_r[i]);
      end
      o_pin_oe_n <= ~out_en_r[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration outputs
  assign o_int_ref_sel    = gen_r[GEN_ADC_REF];
  assign o_diode_check_on = ~gen_r[GEN_DIODE_OFF];
  assign o_limit_amp_ctrl = gen_r[GEN_LIMIT_CTRL];
  assign o_curr_gain      = gain_r;
  assign o_temp_bg_en     = temp_bg_r;
  assign o_curr_bg_en     = curr_bg_r;
  assign o_mon_bg_en      = mon_bg_r;
  assign o_loop_limit_cfg_valid = |loop_r;

  ////////////////////////////////////////////////////////////////////////////
  // read mux, registered
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 16'h0000;
    end else if (i_req.rd) begin
      case (i_req.addr)
        OFS_PIN_OUT_EN:  o_rdata <= out_en_r;
        OFS_PIN_FUNC:    o_rdata <= func_r;
        OFS_PIN_POL:     o_rdata <= pol_r;
        OFS_GENERAL:     o_rdata <= gen_r;
        OFS_ACQ_DELAY:   o_rdata <= acq_r;
        OFS_TEMP_BG:     o_rdata <= temp_bg_r;
        OFS_CURR_BG:     o_rdata <= curr_bg_r;
        OFS_CURR_GAIN:   o_rdata <= gain_r;
        OFS_CLAMP_SLP0:  o_rdata <= clp0_r;
        OFS_CLAMP_SLP1:  o_rdata <= clp1_r;
        OFS_MON_BG:      o_rdata <= mon_bg_r;
        OFS_LOOP_LIMIT:  o_rdata <= loop_r;
        OFS_AMP_ON_CTRL: o_rdata <= amp_r;
        OFS_RAMP_CH0:    o_rdata <= ramp_r[0];
        OFS_RAMP_CH1:    o_rdata <= ramp_r[1];
        OFS_RAMP_CH2:    o_rdata <= ramp_r[2];
        OFS_RAMP_CH3:    o_rdata <= ramp_r[3];
        OFS_FAST_RAMP:   o_rdata <= fast_r;
        OFS_ALARM_MASK:  o_rdata <= mask_r;
        OFS_DAC_ENABLE:  o_rdata <= {8'h00, dac_en_r};
        default:         o_rdata <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_sleep_with_clamp;
    amp_r[AMP_CLAMP_EN] && sleep_any;
  endsequence

  a_amp_sleep_off: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    s_sleep_with_clamp |=> !o_amp_on_pin)
    else $error("amp-on pin stayed on during sleep clamp");
  a_amp_alarm_off: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    amp_alarm_hold |=> !o_amp_on_pin)
    else $error("amp-on pin on during supply alarm");
  a_amp_snooze_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    amp_latch_off_r && !(wr_hit && i_req.addr == OFS_AMP_ON_CTRL) |=> amp_latch_off_r)
    else $error("amp snooze latch released without write");
  a_dac_clamp_s0: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    first_sleep_pin |-> ((o_dac_clamp & clp0_r[7:0]) == clp0_r[7:0]))
    else $error("dac not clamped by first sleep");
  a_dac_clamp_s1: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    second_sleep_pin |-> ((o_dac_clamp & clp1_r[7:0]) == clp1_r[7:0]))
    else $error("dac not clamped by second sleep");
  a_dac_snooze_down: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (clamp_now[0] && snooze[0]) |=> !dac_en_r[0])
    else $error("snoozed dac kept power after clamp");
  a_mask_hides: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    mask_r[MSK_SUPPLY_BIT] |-> !o_alert_status[4])
    else $error("masked supply alarm visible");
  a_acq_delay_len: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_acq_start && !acq_busy_r && acq_r == 16'h1) |-> ##33 o_acq_done)
    else $error("acquisition delay not 320 ns per count");
  a_ramp_bounds: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (ramp_r[0] != 16'h0) |-> (ramp_eff[0] >= RAMP_MIN_CNT && ramp_eff[0] <= RAMP_MAX_CNT))
    else $error("ramp outside 4 ms to 31.75 ms");
  a_oe_follows: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    1'b1 |=> o_pin_oe_n == ~$past(out_en_r[7:0]))
    else $error("pin output enable does not follow register");

endmodule

// File: inc/pacr_pkg.sv
// package: register map, reset values, field positions and timing for the pa config bank
package pacr_pkg;

  // register offsets (byte-wide address space of the serial interface)
  localparam logic [7:0] OFS_PIN_OUT_EN   = 8'h11;
  localparam logic [7:0] OFS_PIN_FUNC     = 8'h12;
  localparam logic [7:0] OFS_PIN_POL      = 8'h13;
  localparam logic [7:0] OFS_GENERAL      = 8'h14;
  localparam logic [7:0] OFS_ACQ_DELAY    = 8'h1a;
  localparam logic [7:0] OFS_TEMP_BG      = 8'h1b;
  localparam logic [7:0] OFS_CURR_BG      = 8'h1c;
  localparam logic [7:0] OFS_CURR_GAIN    = 8'h1d;
  localparam logic [7:0] OFS_CLAMP_SLP0   = 8'h1f;
  localparam logic [7:0] OFS_CLAMP_SLP1   = 8'h20;
  localparam logic [7:0] OFS_MON_BG       = 8'h23;
  localparam logic [7:0] OFS_LOOP_LIMIT   = 8'h28;
  localparam logic [7:0] OFS_AMP_ON_CTRL  = 8'h29;
  localparam logic [7:0] OFS_RAMP_CH0     = 8'h2a;
  localparam logic [7:0] OFS_RAMP_CH1     = 8'h2b;
  localparam logic [7:0] OFS_RAMP_CH2     = 8'h2c;
  localparam logic [7:0] OFS_RAMP_CH3     = 8'h2d;
  localparam logic [7:0] OFS_FAST_RAMP    = 8'h2e;
  localparam logic [7:0] OFS_ALARM_MASK   = 8'h2f;
  localparam logic [7:0] OFS_DAC_ENABLE   = 8'h30;

  // reset values
  localparam logic [15:0] RST_PIN_OUT_EN  = 16'h0010;
  localparam logic [15:0] RST_PIN_FUNC    = 16'h000f;
  localparam logic [15:0] RST_PIN_POL     = 16'h0090;
  localparam logic [15:0] RST_ZERO        = 16'h0000;
  localparam logic [15:0] RST_CLAMP_SLP   = 16'hff00;
  localparam logic [15:0] RST_AMP_ON_CTRL = 16'h0130;
  localparam logic [15:0] RST_FAST_RAMP   = 16'hbbbb;

  // writable masks (reserved bits read zero)
  localparam logic [15:0] MSK_BYTE        = 16'h00ff;
  localparam logic [15:0] MSK_GENERAL     = 16'h00fe;
  localparam logic [15:0] MSK_ALL         = 16'hffff;

  // general register fields
  localparam int GEN_ADC_REF    = 7;
  localparam int GEN_GPIO_ALERT = 6;
  localparam int GEN_DIODE_OFF  = 3;
  localparam int GEN_LIMIT_CTRL = 2;
  localparam int GEN_A0_CLAMP   = 1;

  // clamp register: low byte clamp per dac, high byte snooze per dac
  localparam int CLP_SNOOZE_LSB = 8;

  // amp-on control fields
  localparam int AMP_ON_BIT     = 0;
  localparam int AMP_ALARM_EN   = 4;
  localparam int AMP_CLAMP_EN   = 5;
  localparam int AMP_SNOOZE     = 8;

  // alarm mask: bits 3..0 integrator limits, bit 4 supply alarm
  localparam int MSK_SUPPLY_BIT = 4;

  // multifunction pin indices
  localparam int PIN_LOAD   = 7;
  localparam int PIN_SECOND_SLEEP_PIN = 6;
  localparam int PIN_FIRST_SLEEP_PIN = 5;
  localparam int PIN_SECOND_ALERT_OUT = 4;
  localparam int PIN_FIRST_ALERT_OUT = 3;

  // timing
  localparam int CLK_PERIOD_PS     = 10000;
  localparam int ACQ_STEP_PS       = 320000;
  localparam int ACQ_STEP_CYC      = (ACQ_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RAMP_STEP_US      = 250;
  localparam int RAMP_STEP_CYC_DEF = RAMP_STEP_US * 1000000 / CLK_PERIOD_PS;
  localparam logic [15:0] RAMP_MAX_CNT = 16'h007f; // 31.75 ms / 250 us
  localparam logic [15:0] RAMP_MIN_CNT = 16'h0010; // 4 ms / 250 us

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } pacr_req_t;

endpackage

// File: verification/pacr_host_model.sv
// host-side model issuing register requests on the core clock
`timescale 1ns/1ps
module pacr_host_model
  import pacr_pkg::*;
(
  // clock
  input  wire logic        i_ref_clk,
  // request and answer
  output pacr_req_t        o_req,
  input  wire logic [15:0] i_rdata
);
  initial o_req = '0;
  // released address and data show the inverse, so stale values never match
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge i_ref_clk);
    #1;
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_ref_clk);
    #1;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(logic [7:0] a, output logic [15:0] d);
    @(posedge i_ref_clk);
    #1;
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge i_ref_clk);
    #1;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hffff};
    d = i_rdata;
  endtask
endmodule

// File: verification/testbench.sv
// self-checking bench for the pa config register bank
`timescale 1ns/1ps
module testbench;
  import pacr_pkg::*;
  localparam int STEP = 10;
  localparam logic [7:0] OFS [8] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h1a, 8'h1f, 8'h29, 8'h2e};
  localparam logic [15:0] RST [8] = '{16'h0010, 16'h000f, 16'h0090, 16'h0000, 16'h0000,
                                       16'hff00, 16'h0130, 16'hbbbb};
  localparam logic [15:0] RV [4] = '{16'h0000, 16'h0010, 16'h0001, 16'h00c8};
  localparam int GP [4] = '{1, 16 * STEP, 16 * STEP, 127 * STEP};
  logic        i_ref_clk = 1'b0;
  logic        i_rstn    = 1'b0;
  pacr_req_t   req;
  logic [15:0] rdata, rv, gain, tbg, cbg, mbg;
  logic [7:0]  pin_in = 8'h00;
  logic [7:0]  clamp, pwr, oe_n, pout;
  logic [4:0]  ralert = 5'h00;
  logic [11:0] itc;
  logic        alarm = 1'b0;
  logic        acq   = 1'b0;
  logic [3:0]  lim   = 4'h0;
  logic [3:0]  tgt   = 4'h0;
  logic [3:0]  step, fast;
  logic [4:0]  alst;
  logic        done, amp, iref, dchk, lctl;
  int          fails = 0;
  int          checks_done = 0;
  int          n;
  always #5 i_ref_clk = ~i_ref_clk;
  pacr_host_model host (.i_ref_clk(i_ref_clk), .o_req(req), .i_rdata(rdata));
  pacr_regs #(.RAMP_STEP_CYC(STEP)) dut (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_req(req), .o_rdata(rdata),
    .i_pin_in(pin_in), .i_gpio_out(8'h00), .o_pin_out(pout), .o_pin_oe_n(oe_n),
    .i_conv_busy(1'b0), .i_raw_alert(ralert), .i_integrator_limit_status(lim),
    .i_supply_alarm(alarm), .i_acq_start(acq), .i_ramp_target_step(tgt),
    .o_acq_done(done), .o_dac_clamp(clamp), .o_dac_powered(pwr), .o_amp_on_pin(amp),
    .o_ramp_step(step), .o_fast_ramp_en(fast), .o_integrator_tc(itc), .o_int_ref_sel(iref),
    .o_diode_check_on(dchk), .o_limit_amp_ctrl(lctl), .o_curr_gain(gain),
    .o_temp_bg_en(tbg), .o_curr_bg_en(cbg), .o_mon_bg_en(mbg), .o_alert_status(alst),
    .o_loop_limit_cfg_valid());
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic rchk(logic [7:0] a, logic [15:0] e);
    host.rd(a, rv);
    chk("reg", e, rv);
  endtask
  // spacing between two step pulses of channel 0, bounded wait
  task automatic gap(int e);
    n = 0;
    while (step[0] !== 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (step[0] !== 1'b1 && n < 2000);
    chk("ramp gap", e[15:0], n[15:0]);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #300000;
    fails++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(20);
    i_rstn = 1'b1;
    foreach (OFS[i]) rchk(OFS[i], RST[i]);
    chk("oe_n", 16'h00ef, {8'h00, oe_n});
    chk("fast", 16'h000f, {12'h000, fast});
    chk("itc", 16'h06db, {4'h0, itc});
    chk("pin_out", 16'h0090, {8'h00, pout});
    host.wr(OFS_GENERAL, 16'hffff);
    rchk(OFS_GENERAL, 16'h00fe);
    chk("gen", 16'h0005, {13'h0000, iref, dchk, lctl});
    rchk(8'h0e, 16'h0000);
    host.wr(OFS_CURR_GAIN, 16'h1234);
    host.wr(OFS_TEMP_BG, 16'h00a5);
    host.wr(OFS_CURR_BG, 16'h005a);
    host.wr(OFS_MON_BG, 16'h0f0f);
    host.wr(OFS_FAST_RAMP, 16'h0008);
    chk("gain", 16'h1234, gain);
    chk("bg", 16'ha55a, {tbg[7:0], cbg[7:0]});
    chk("mon", 16'h0f0f, mbg);
    chk("fast", 16'h0001, {12'h000, fast});
    chk("itc", 16'h0000, {4'h0, itc});
    host.wr(OFS_ACQ_DELAY, 16'h0001);
    acq = 1'b1;
    cyc(1);
    acq = 1'b0;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (done !== 1'b1 && n < 100);
    chk("acq", 16'd32, n[15:0]);
    // first_sleep_pin clamps dacs 0,1; only dac 0 snoozes
    host.wr(OFS_CLAMP_SLP0, 16'h0103);
    pin_in[5] = 1'b1;
    cyc(4);
    chk("clamp", 16'h0003, {8'h00, clamp});
    pin_in[5] = 1'b0;
    cyc(4);
    chk("pwr", 16'h00fe, {8'h00, pwr});
    host.wr(OFS_DAC_ENABLE, 16'h00ff);
    chk("pwr", 16'h00ff, {8'h00, pwr});
    host.wr(OFS_AMP_ON_CTRL, 16'h0031);
    cyc(2);
    chk("amp", 16'h0001, {15'h0000, amp});
    alarm = 1'b1;
    cyc(4);
    chk("amp", 16'h0000, {15'h0000, amp});
    alarm = 1'b0;
    host.wr(OFS_AMP_ON_CTRL, 16'h0131);
    cyc(2);
    chk("amp", 16'h0001, {15'h0000, amp});
    host.wr(OFS_CLAMP_SLP1, 16'h0080);
    pin_in[6] = 1'b1;
    cyc(4);
    chk("clamp", 16'h0080, {8'h00, clamp});
    chk("amp", 16'h0000, {15'h0000, amp});
    pin_in[6] = 1'b0;
    cyc(4);
    chk("amp", 16'h0000, {15'h0000, amp});
    chk("pwr", 16'h00ff, {8'h00, pwr});
    host.wr(OFS_AMP_ON_CTRL, 16'h0131);
    cyc(2);
    chk("amp", 16'h0001, {15'h0000, amp});
    lim = 4'hf;
    alarm = 1'b1;
    ralert = 5'h1f;
    cyc(3);
    chk("alert", 16'h001f, {11'h000, alst});
    chk("clamp", 16'h000f, {8'h00, clamp});
    chk("second_alert_out pin", 16'h0000, {15'h0000, pout[PIN_SECOND_ALERT_OUT]});
    host.wr(OFS_ALARM_MASK, 16'h0011);
    cyc(2);
    chk("alert", 16'h000e, {11'h000, alst});
    host.wr(OFS_ALARM_MASK, 16'h001f);
    cyc(2);
    chk("alert", 16'h0000, {11'h000, alst});
    chk("clamp", 16'h0000, {8'h00, clamp});
    chk("second_alert_out pin", 16'h0001, {15'h0000, pout[PIN_SECOND_ALERT_OUT]});
    pin_in[0] = 1'b1;
    cyc(4);
    chk("second_alert_out pin", 16'h0000, {15'h0000, pout[PIN_SECOND_ALERT_OUT]});
    foreach (RV[i]) begin
      tgt = 4'h0;
      host.wr(OFS_RAMP_CH0, RV[i]);
      tgt = 4'h1;
      gap(GP[i]);
    end
    conclude();
  end
endmodule
